// ==== hw/sroc_top.sv ====
// Purpose: Register bank and output control for system-reference outputs
// Assumes: Serial port decoder presents byte writes and reads on reg_*
// Notes: Reserved bits read zero; unmapped addresses read zero
//
// Functional notes
// - Source select 0 routes the channel clock to the output.
// - Source select 1 routes central SYSREF; the field is RW, reset 1.
// - Coarse delay is code times 254 ps, reset code 000.
// - Fine delay adds 0,25,50,75,85,110,135,160 ps, reset code 000.
// - Bias flag biases to LVDS cross-point only with global bias type 1.
// - Amplitude 00..11 gives 250,500,750,1000 mV in both formats.
// - Power-down 1 powers the output off and overrides the rest except the delay.
// - Format bit 0 is LVDS and 1 is LVPECL, reset 0.
// - Enable 0 holds the output low; enable 1 drives the signal.

`timescale 1ns/100ps

module sroc_top #(
	parameter int NUM_OUT = sroc_pkg::NUM_OUT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [sroc_pkg::AW-1:0] reg_addr,
	input wire logic [sroc_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sroc_pkg::DW-1:0] reg_rdata,
	// Global control
	input wire logic bias_type,
	// Signal sources
	input wire logic [NUM_OUT-1:0] chan_clk,
	input wire logic sysref_in,
	// Output path
	output logic [NUM_OUT-1:0] out_signal,
	output logic [NUM_OUT-1:0] out_powered,
	output logic [NUM_OUT-1:0] out_lvpecl,
	output logic [NUM_OUT-1:0] out_bias,
	output logic [NUM_OUT-1:0][sroc_pkg::DLY_W-1:0] out_delay_ps,
	output logic [NUM_OUT-1:0][sroc_pkg::AMP_W-1:0] out_amp_mv
);

	// ************************************************************
	// Configuration storage
	// ************************************************************
	logic [NUM_OUT-1:0] mux;
	logic [NUM_OUT-1:0][2:0] coarse;
	logic [NUM_OUT-1:0][2:0] fine;
	logic [NUM_OUT-1:0] bias;
	logic [NUM_OUT-1:0][1:0] amp;
	logic [NUM_OUT-1:0] pd;
	logic [NUM_OUT-1:0] style;
	logic [NUM_OUT-1:0] en;

	// ************************************************************
	// Address decode
	// ************************************************************
	logic [NUM_OUT-1:0] hit_dly;
	logic [NUM_OUT-1:0] hit_st;
	logic hit_en;

	// One hit line per register, shared by the write and read paths
	// so that both always agree on which byte an address selects
	always_comb begin
		hit_en = (reg_addr == sroc_pkg::ENABLE_ADDR);
		for (int i = 0; i < NUM_OUT; i++) begin
			hit_dly[i] = (reg_addr == sroc_pkg::DELAY_ADDR[i]);
			hit_st[i] = (reg_addr == sroc_pkg::STATE_ADDR[i]);
		end
	end

	// ************************************************************
	// Per-output field registers and output channel
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			logic wr_dly;
			logic wr_st;
			logic next_mux;
			logic [2:0] next_coarse;
			logic [2:0] next_fine;
			logic next_bias;
			logic [1:0] next_amp;
			logic next_pd;
			logic next_style;
			logic next_en;

			// Field updates on a write to this output's registers;
			// a read in the same cycle still returns the old value
			always_comb begin
				wr_dly = reg_wr && hit_dly[g];
				wr_st = reg_wr && hit_st[g];
				next_mux = mux[g];
				next_coarse = coarse[g];
				next_fine = fine[g];
				next_bias = bias[g];
				next_amp = amp[g];
				next_pd = pd[g];
				next_style = style[g];
				next_en = en[g];
				if (wr_dly) begin
					next_mux = reg_wdata[sroc_pkg::MUX_POS];
					next_coarse = reg_wdata[sroc_pkg::COARSE_POS +: 3];
					next_fine = {reg_wdata[sroc_pkg::FINE_HI_POS],
						reg_wdata[sroc_pkg::FINE_LO_POS +: 2]};
				end
				if (wr_st) begin
					next_pd = reg_wdata[sroc_pkg::PD_POS];
					next_bias = reg_wdata[sroc_pkg::BIAS_POS];
					next_style = reg_wdata[sroc_pkg::STYLE_POS];
					next_amp = reg_wdata[sroc_pkg::AMP_POS +: 2];
				end
				// Enable bits packed MSB-first, output 0 in bit 7
				if (reg_wr && hit_en) begin
					next_en = reg_wdata[NUM_OUT-1-g];
				end
			end

			// Defaults restored on reset; asynchronous so the outputs
			// are in a safe state before the first clock arrives
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					mux[g] <= sroc_pkg::RST_MUX;
					coarse[g] <= sroc_pkg::RST_COARSE;
					fine[g] <= sroc_pkg::RST_FINE;
					bias[g] <= sroc_pkg::RST_BIAS;
					amp[g] <= sroc_pkg::RST_AMP;
					pd[g] <= sroc_pkg::RST_PD;
					style[g] <= sroc_pkg::RST_STYLE;
					en[g] <= sroc_pkg::RST_EN;
				end else begin
					mux[g] <= next_mux;
					coarse[g] <= next_coarse;
					fine[g] <= next_fine;
					bias[g] <= next_bias;
					amp[g] <= next_amp;
					pd[g] <= next_pd;
					style[g] <= next_style;
					en[g] <= next_en;
				end
			end

			sroc_channel u_chan (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.cfg_mux(mux[g]),
				.cfg_coarse(coarse[g]),
				.cfg_fine(fine[g]),
				.cfg_bias(bias[g]),
				.cfg_amp(amp[g]),
				.cfg_pd(pd[g]),
				.cfg_style(style[g]),
				.cfg_en(en[g]),
				.bias_type(bias_type),
				.chan_clk(chan_clk[g]),
				.sysref_in(sysref_in),
				.out_signal(out_signal[g]),
				.out_powered(out_powered[g]),
				.out_lvpecl(out_lvpecl[g]),
				.out_bias(out_bias[g]),
				.out_delay_ps(out_delay_ps[g]),
				.out_amp_mv(out_amp_mv[g])
			);
		end
	endgenerate

	// ************************************************************
	// Read-back
	// ************************************************************
	logic [NUM_OUT-1:0][sroc_pkg::DW-1:0] img_dly;
	logic [NUM_OUT-1:0][sroc_pkg::DW-1:0] img_st;
	logic [sroc_pkg::DW-1:0] img_en;
	logic [sroc_pkg::DW-1:0] next_rdata;

	// Register images in bus layout; reserved bits are tied low here
	always_comb begin
		img_en = '0;
		for (int i = 0; i < NUM_OUT; i++) begin
			img_dly[i] = '0;
			img_dly[i][sroc_pkg::MUX_POS] = mux[i];
			img_dly[i][sroc_pkg::COARSE_POS +: 3] = coarse[i];
			img_dly[i][sroc_pkg::FINE_LO_POS +: 2] = fine[i][1:0];
			img_dly[i][sroc_pkg::FINE_HI_POS] = fine[i][2];
			img_st[i] = '0;
			img_st[i][sroc_pkg::PD_POS] = pd[i];
			img_st[i][sroc_pkg::BIAS_POS] = bias[i];
			img_st[i][sroc_pkg::STYLE_POS] = style[i];
			img_st[i][sroc_pkg::AMP_POS +: 2] = amp[i];
			// Enable byte is MSB-first: output 0 sits in bit 7
			img_en[NUM_OUT-1-i] = en[i];
		end
	end

	// Unmapped addresses read zero; data held between reads so a
	// slow serial shifter can pick it up at its own pace
	always_comb begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			next_rdata = '0;
			for (int i = 0; i < NUM_OUT; i++) begin
				if (hit_dly[i]) begin
					next_rdata = img_dly[i];
				end
				if (hit_st[i]) begin
					next_rdata = img_st[i];
				end
			end
			if (hit_en) begin
				next_rdata = img_en;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // sroc_top

// ==== common/sroc_pkg.sv ====
// Purpose: Shared constants for the system-reference output configuration
// Assumes: Byte-wide register port behind the serial configuration port
// Notes: Eight outputs, two field registers each, one shared enable register

package sroc_pkg;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int NUM_OUT = 8;
	localparam int AW = 8;
	localparam int DW = 8;
	localparam int DLY_W = 11;
	localparam int AMP_W = 11;

	// ************************************************************
	// Register offsets, output order A0 A1 A2 B0 B1 C0 C1 D
	// ************************************************************
	localparam logic [7:0] DELAY_ADDR [NUM_OUT] = '{8'h28, 8'h29, 8'h2a,
		8'h38, 8'h39, 8'h48, 8'h49, 8'h58};
	localparam logic [7:0] STATE_ADDR [NUM_OUT] = '{8'h2c, 8'h2d, 8'h2e,
		8'h3c, 8'h3d, 8'h4c, 8'h4d, 8'h5c};
	localparam logic [7:0] ENABLE_ADDR = 8'h76;

	// ************************************************************
	// Field positions, delay register
	// ************************************************************
	localparam int FINE_LO_POS = 5;
	localparam int MUX_POS = 4;
	localparam int COARSE_POS = 1;
	localparam int FINE_HI_POS = 0;

	// ************************************************************
	// Field positions, state register
	// ************************************************************
	localparam int PD_POS = 7;
	localparam int BIAS_POS = 5;
	localparam int STYLE_POS = 4;
	localparam int AMP_POS = 2;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic RST_MUX = 1'b1;
	localparam logic [2:0] RST_COARSE = 3'h0;
	localparam logic [2:0] RST_FINE = 3'h0;
	localparam logic RST_BIAS = 1'b0;
	localparam logic [1:0] RST_AMP = 2'h0;
	localparam logic RST_PD = 1'b0;
	localparam logic RST_STYLE = 1'b0;
	localparam logic RST_EN = 1'b0;

	// ************************************************************
	// Encodings and delay / amplitude figures
	// ************************************************************
	localparam logic SRC_CLOCK = 1'b0;
	localparam logic SRC_SYSREF = 1'b1;
	localparam logic STYLE_LVDS = 1'b0;
	localparam logic STYLE_LVPECL = 1'b1;
	localparam logic [DLY_W-1:0] COARSE_STEP_PS = 11'h0fe;
	localparam logic [DLY_W-1:0] FINE_PS [8] = '{11'h000, 11'h019,
		11'h032, 11'h04b, 11'h055, 11'h06e, 11'h087, 11'h0a0};
	localparam logic [AMP_W-1:0] AMP_STEP_MV = 11'h0fa;

endpackage

// ==== hw/sroc_channel.sv ====
// Purpose: One system-reference output: source select, delay, drive decode
// Assumes: Channel clock and central SYSREF arrive from outside this clock
// Notes: Outputs are registered; delay is given in picoseconds, coarse plus fine

`timescale 1ns/100ps

module sroc_channel (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Configuration
	input wire logic cfg_mux,
	input wire logic [2:0] cfg_coarse,
	input wire logic [2:0] cfg_fine,
	input wire logic cfg_bias,
	input wire logic [1:0] cfg_amp,
	input wire logic cfg_pd,
	input wire logic cfg_style,
	input wire logic cfg_en,
	input wire logic bias_type,
	// Signal sources
	input wire logic chan_clk,
	input wire logic sysref_in,
	// Output path
	output logic out_signal,
	output logic out_powered,
	output logic out_lvpecl,
	output logic out_bias,
	output logic [sroc_pkg::DLY_W-1:0] out_delay_ps,
	output logic [sroc_pkg::AMP_W-1:0] out_amp_mv
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [2:0] clk_sync;
	logic [2:0] ref_sync;
	logic clk_filt;
	logic ref_filt;
	logic [2:0] next_clk_sync;
	logic [2:0] next_ref_sync;
	logic next_clk_filt;
	logic next_ref_filt;

	// Change accepted once stages two and three agree
	always_comb begin
		next_clk_sync = {clk_sync[1:0], chan_clk};
		next_ref_sync = {ref_sync[1:0], sysref_in};
		next_clk_filt = (clk_sync[2] == clk_sync[1]) ? clk_sync[2] : clk_filt;
		next_ref_filt = (ref_sync[2] == ref_sync[1]) ? ref_sync[2] : ref_filt;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_sync <= 3'h0;
			ref_sync <= 3'h0;
			clk_filt <= 1'b0;
			ref_filt <= 1'b0;
		end else begin
			clk_sync <= next_clk_sync;
			ref_sync <= next_ref_sync;
			clk_filt <= next_clk_filt;
			ref_filt <= next_ref_filt;
		end
	end

	// ************************************************************
	// Output decode
	// ************************************************************
	logic next_signal;
	logic next_powered;
	logic next_lvpecl;
	logic next_bias;
	logic [sroc_pkg::DLY_W-1:0] next_delay;
	logic [sroc_pkg::AMP_W-1:0] next_amp;
	logic src;

	// Power-down wins over format, enable and amplitude
	always_comb begin
		src = (cfg_mux == sroc_pkg::SRC_SYSREF) ?
			ref_filt : clk_filt;
		next_powered = !cfg_pd;
		next_signal = !cfg_pd && cfg_en && src;
		next_lvpecl = !cfg_pd &&
			(cfg_style == sroc_pkg::STYLE_LVPECL);
		// Bias flag is inert unless the global bias type is set
		next_bias = !cfg_pd && cfg_bias && bias_type;
		next_amp = cfg_pd ? '0 :
			sroc_pkg::AMP_W'(({9'h0, cfg_amp} + 11'h001)
			* sroc_pkg::AMP_STEP_MV);
		// Coarse steps plus the nonlinear fine table
		next_delay = sroc_pkg::DLY_W'({8'h0, cfg_coarse}
			* sroc_pkg::COARSE_STEP_PS)
			+ sroc_pkg::FINE_PS[cfg_fine];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_signal <= 1'b0;
			out_powered <= 1'b0;
			out_lvpecl <= 1'b0;
			out_bias <= 1'b0;
			out_delay_ps <= '0;
			out_amp_mv <= '0;
		end else begin
			out_signal <= next_signal;
			out_powered <= next_powered;
			out_lvpecl <= next_lvpecl;
			out_bias <= next_bias;
			out_delay_ps <= next_delay;
			out_amp_mv <= next_amp;
		end
	end

endmodule // sroc_channel

// ==== dv/sroc_checker.sv ====
// Purpose: Port-level checks on the output configuration bank
// Assumes: One ref_clk domain, reset_n asynchronous active low
// Notes: Output 0 stands for all outputs in the numeric range checks

`timescale 1ns/100ps

module sroc_checker #(
	parameter int NUM_OUT = sroc_pkg::NUM_OUT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Register port and global control
	input wire logic reg_rd,
	input wire logic [sroc_pkg::DW-1:0] reg_rdata,
	input wire logic bias_type,
	input wire logic sysref_in,
	// Output path
	input wire logic [NUM_OUT-1:0] out_signal,
	input wire logic [NUM_OUT-1:0] out_powered,
	input wire logic [NUM_OUT-1:0] out_lvpecl,
	input wire logic [NUM_OUT-1:0] out_bias,
	input wire logic [NUM_OUT-1:0][sroc_pkg::DLY_W-1:0] out_delay_ps,
	input wire logic [NUM_OUT-1:0][sroc_pkg::AMP_W-1:0] out_amp_mv
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// Power-down overrides every drive setting
	a_pd_signal_low: assert property (
		(out_signal & ~out_powered) == '0)
		else $error("signal driven on a powered-down output");
	a_pd_format_off: assert property (
		(out_lvpecl & ~out_powered) == '0)
		else $error("format set on a powered-down output");
	a_pd_bias_off: assert property (
		(out_bias & ~out_powered) == '0)
		else $error("bias set on a powered-down output");
	a_pd_amp_zero: assert property (
		!out_powered[0] |-> out_amp_mv[0] == '0)
		else $error("amplitude left on while powered down");
	// Settled bias type low means no bias anywhere
	a_bias_type_gate: assert property (
		!bias_type [*3] |-> out_bias == '0)
		else $error("bias applied with bias type low");
	a_amp_levels: assert property (
		out_powered[0] |-> out_amp_mv[0] inside
		{11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8})
		else $error("amplitude outside the four levels");
	a_delay_range: assert property (
		out_delay_ps[0] <= 11'h792)
		else $error("delay above coarse and fine maximum");
	// Defaults show on the edge after release
	a_reset_default: assert property (
		$rose(reset_n) |=> out_powered == '1 && out_signal == '0)
		else $error("outputs not at defaults after reset");
	a_rdata_holds: assert property (
		!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data changed without a read");

	c_bias_on: cover property (out_bias[0]);
	c_pd_on: cover property (!out_powered[0]);
	c_sysref_out: cover property (out_signal[0] && sysref_in);
endmodule // sroc_checker

bind sroc_top sroc_checker #(.NUM_OUT(NUM_OUT)) u_sroc_checker (
	.ref_clk(ref_clk), .reset_n(reset_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .bias_type(bias_type), .sysref_in(sysref_in),
	.out_signal(out_signal), .out_powered(out_powered),
	.out_lvpecl(out_lvpecl), .out_bias(out_bias),
	.out_delay_ps(out_delay_ps), .out_amp_mv(out_amp_mv));

// ==== dv/sroc_host.sv ====
// Purpose: Host model driving the byte register port
// Assumes: Callers enter just after a rising edge
// Notes: Idle cycle after each access so no strobe toggles twice at once

`timescale 1ns/100ps

module sroc_host (
	// Clock
	input wire logic ref_clk,
	// Register port
	output logic [sroc_pkg::AW-1:0] reg_addr,
	output logic [sroc_pkg::DW-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [sroc_pkg::DW-1:0] reg_rdata
);
	// Quiet bus from time zero
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end

	// Released lines show the inverse, never a stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(posedge ref_clk);
		#1 reg_wr = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
		@(posedge ref_clk);
		#1;
	endtask

	// Data is held until the next read, taken one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'h1;
		@(posedge ref_clk);
		#1 reg_rd = 1'h0;
		reg_addr = ~a;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask
endmodule // sroc_host

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the output configuration bank
// Assumes: Host model owns the register port, bench drives the rest
// Notes: Register images in integers form the reference model

`timescale 1ns/100ps

module tb;
	logic ref_clk = 0, reset_n = 0, bias_type = 0, sysref_in = 0;
	logic reg_wr, reg_rd;
	logic [7:0] chan_clk = '0, reg_addr, reg_wdata, reg_rdata, out_signal;
	logic [7:0] out_powered, out_lvpecl, out_bias;
	logic [7:0][10:0] out_delay_ps, out_amp_mv;
	int error_cnt = 0, checks_done = 0, dl[8], st[8], en;
	int fine_ps[8] = '{0, 25, 50, 75, 85, 110, 135, 160};

	sroc_top u_sroc_top (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bias_type(bias_type),
		.chan_clk(chan_clk), .sysref_in(sysref_in), .out_signal(out_signal),
		.out_powered(out_powered), .out_lvpecl(out_lvpecl),
		.out_bias(out_bias), .out_delay_ps(out_delay_ps),
		.out_amp_mv(out_amp_mv));
	sroc_host u_sroc_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	// 50 MHz clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic cmp(string what, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_cyc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Model outputs from register images; sources held long enough
	task automatic check_all;
		int pd, dly, amp, sig;
		for (int i = 0; i < 8; i++) begin
			pd = st[i][7];
			dly = dl[i][3:1] * 254 + fine_ps[{dl[i][0], dl[i][6:5]}];
			amp = pd ? 0 : (st[i][3:2] + 1) * 250;
			sig = dl[i][4] ? sysref_in : chan_clk[i];
			cmp("powered", out_powered[i], !pd);
			cmp("format", out_lvpecl[i], !pd && st[i][4]);
			cmp("bias", out_bias[i], !pd && st[i][5] && bias_type);
			cmp("delay", out_delay_ps[i], dly);
			cmp("amp", out_amp_mv[i], amp);
			cmp("signal", out_signal[i], !pd && en[7-i] && sig);
		end
	endtask

	task automatic check_regs(int i);
		logic [7:0] d;
		u_sroc_host.rd(sroc_pkg::DELAY_ADDR[i], d);
		cmp("delay reg", d, dl[i]);
		u_sroc_host.rd(sroc_pkg::STATE_ADDR[i], d);
		cmp("state reg", d, st[i]);
		u_sroc_host.rd(sroc_pkg::ENABLE_ADDR, d);
		cmp("enable reg", d, en);
		u_sroc_host.rd(8'h77, d);
		cmp("unmapped", d, 0);
	endtask

	// Twenty-cycle reset, then defaults everywhere
	task automatic reset_check(int i);
		reset_n = 0;
		repeat (20) @(posedge ref_clk);
		#1 reset_n = 1;
		foreach (dl[k]) begin
			dl[k] = 'h10;
			st[k] = 0;
		end
		en = 0;
		wait_cyc(2);
		check_all;
		check_regs(i);
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Random configuration rounds with a reset in mid-run
	initial begin
		int i;
		logic [7:0] d, s;
		void'($urandom(32'hd3ad));
		reset_check(0);
		for (int n = 0; n < 48; n++) begin
			if (n == 24)
				reset_check(7);
			i = $urandom_range(7);
			d = $urandom;
			s = $urandom;
			if (s[4])
				s[5] = 0;
			en = $urandom_range(255);
			u_sroc_host.wr(sroc_pkg::DELAY_ADDR[i], d);
			u_sroc_host.wr(sroc_pkg::STATE_ADDR[i], s);
			u_sroc_host.wr(sroc_pkg::ENABLE_ADDR, en[7:0]);
			u_sroc_host.wr(8'h77, ~d);
			dl[i] = d & 8'h7f;
			st[i] = s & 8'hbc;
			bias_type = $urandom;
			sysref_in = $urandom;
			chan_clk = $urandom;
			wait_cyc(6);
			check_all;
			check_regs(i);
		end
		conclude;
	end

	// Hang guard, well past the expected run
	initial begin
		#200000;
		error_cnt++;
		conclude;
	end
endmodule // tb
